// File: common/mls_pkg.sv
`default_nettype none
package mls_pkg;
    // Register map
    localparam logic [7:0] MEAS_CTRL_OFS = 8'h0A;
    localparam int CTRL_W = 16;
    localparam int OPC_LSB = 0;
    localparam int PULL_BIT = 2;
    localparam int ADCOFF_BIT = 3;
    localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;

    // Loop control codes
    localparam logic [1:0] OPC_DSPRST = 2'h0;
    localparam logic [1:0] OPC_DSPLOAD = 2'h1;
    localparam logic [1:0] OPC_NORMAL = 2'h2;
    localparam logic [1:0] OPC_FORCE = 2'h3;

    // Reported loop state codes
    localparam logic [1:0] ST_CODE_IDLE = 2'h0;
    localparam logic [1:0] ST_CODE_ARM = 2'h1;
    localparam logic [1:0] ST_CODE_MEAS = 2'h2;
    localparam logic [1:0] ST_CODE_TRIG = 2'h3;

    localparam int SMP_W = 16;
    localparam int FIFO_DEPTH = 16;

    typedef enum {
        LOOP_IDLE,
        LOOP_ARM,
        LOOP_TRIG,
        LOOP_MEAS
    } mls_loop_t;

    typedef struct packed {
        logic adcOff;
        logic pullSync;
        logic [1:0] opcode;
    } mls_ctrl_t;

    typedef struct packed {
        logic valid;
        logic [SMP_W-1:0] data;
    } mls_smp_t;
endpackage
`default_nettype wire

// File: dv/mls_sequencer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mls_sequencer_chk (
    input wire logic clock,
    input wire logic srst,
    input wire logic regWrStb,
    input wire logic [7:0] regAddr,
    input wire logic [mls_pkg::CTRL_W-1:0] regWrData,
    input wire logic syncIn,
    input wire logic syncOe,
    input wire mls_pkg::mls_smp_t mixSmp,
    input wire logic dspReset,
    input wire logic dspLoad,
    input wire logic [1:0] loopState,
    input wire logic collecting
);
    logic [1:0] loopCode_ff;
    logic adcOff_ff;
    logic wrHit;
    assign wrHit = regWrStb && regAddr == mls_pkg::MEAS_CTRL_OFS;
    // Shadow of the write-only control word, force code kept as normal
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            loopCode_ff <= 2'h0;
            adcOff_ff <= 1'b0;
        end
        else if (wrHit)
        begin
            loopCode_ff <= (regWrData[1:0] == 2'h3) ? 2'h2 : regWrData[1:0];
            adcOff_ff <= regWrData[mls_pkg::ADCOFF_BIT];
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    sequence s_fall;
        $fell(syncIn);
    endsequence
    sequence s_rise;
        $rose(syncIn);
    endsequence
    property p_dsp_reset;
        loopCode_ff == mls_pkg::OPC_DSPRST ##0 s_fall |-> ##[1:4] dspReset;
    endproperty
    a_dsp_reset: assert property (p_dsp_reset) else $error("no dsp reset pulse");
    property p_dsp_load;
        loopCode_ff == mls_pkg::OPC_DSPLOAD ##0 s_fall |-> ##[1:4] dspLoad;
    endproperty
    a_dsp_load: assert property (p_dsp_load) else $error("no dsp load pulse");
    property p_pull;
        wrHit && regWrData[mls_pkg::PULL_BIT] |-> ##[1:3] syncOe;
    endproperty
    a_pull: assert property (p_pull) else $error("pull bit not driven");
    property p_idle;
        (loopCode_ff != mls_pkg::OPC_NORMAL) [*3] |-> loopState == 2'h0 && !collecting;
    endproperty
    a_idle: assert property (p_idle) else $error("loop not held idle");
    property p_adc_off;
        adcOff_ff [*2] |-> !mixSmp.valid;
    endproperty
    a_adc_off: assert property (p_adc_off) else $error("mixer fed while off");
    property p_arm;
        loopCode_ff == 2'h2 && loopState == 2'h0 ##0 s_fall |-> ##[1:4] loopState == 2'h1;
    endproperty
    a_arm: assert property (p_arm) else $error("idle did not arm");
    property p_trig;
        loopState == mls_pkg::ST_CODE_TRIG ##0 s_fall |-> ##[1:4] loopState == 2'h2;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger did not measure");
    property p_meas_end;
        loopState == mls_pkg::ST_CODE_MEAS ##0 s_rise |-> ##[1:4] loopState == 2'h0;
    endproperty
    a_meas_end: assert property (p_meas_end) else $error("measure did not end");
    property p_force;
        wrHit && regWrData[1:0] == mls_pkg::OPC_FORCE |-> ##[1:3] loopState == 2'h0;
    endproperty
    a_force: assert property (p_force) else $error("force code not idle");
endmodule
bind mls_sequencer mls_sequencer_chk CHK (.clock, .srst, .regWrStb, .regAddr, .regWrData,
    .syncIn, .syncOe, .mixSmp, .dspReset, .dspLoad, .loopState, .collecting);
`default_nettype wire

// File: dv/mls_sync_peer.sv
`timescale 1ns/1ps
`default_nettype none
module mls_sync_peer (
    input wire logic clock,
    input wire logic srst,
    input wire logic pullReq,
    output logic peerOe
);
    always_ff @(posedge clock)
    begin
        peerOe <= !srst && pullReq;
    end
endmodule
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic regWrStb = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWrData = 16'h0000;
    logic blockMode = 1'b1;
    logic [4:0] preTrigLen = 5'h04;
    logic [4:0] blockLen = 5'h08;
    logic pullReq = 1'b0;
    logic outReady = 1'b0;
    logic capt = 1'b0;
    logic adcOff = 1'b0;
    logic [15:0] mixQ[$];
    logic syncIn, syncOut, syncOe, peerOe, dspReset, dspLoad, collecting;
    logic [1:0] loopState;
    mls_pkg::mls_smp_t adcSmp = '0;
    mls_pkg::mls_smp_t filtSmp = '0;
    mls_pkg::mls_smp_t mixSmp, outSmp;
    int num_errors = 0;
    int checks_done = 0;
    int rstCnt = 0, ldCnt = 0, mixCnt = 0, extra = 0;
    logic [31:0] seed = 32'h0000A8B3;
    logic [15:0] hist[$];
    logic [15:0] expQ[$];
    always #5 clock = ~clock;
    // Open-drain wire with pull-up
    assign syncIn = !(syncOe || peerOe);
    mls_sequencer DUT (.clock, .srst, .regWrStb, .regAddr, .regWrData, .blockMode,
        .preTrigLen, .blockLen, .syncIn, .syncOut, .syncOe, .adcSmp, .mixSmp, .filtSmp,
        .outSmp, .outReady, .dspReset, .dspLoad, .loopState, .collecting);
    mls_sync_peer PEER (.clock, .srst, .pullReq, .peerOe);
    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        checks_done++;
        if (seen !== expv)
        begin
            num_errors++;
            $display("Error at %0t: saw %h want %h", $time, seen, expv);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        regWrStb = 1'b1;
        regAddr = a;
        regWrData = d;
        if (a == mls_pkg::MEAS_CTRL_OFS)
            adcOff = d[mls_pkg::ADCOFF_BIT];
        tick(1);
        regWrStb = 1'b0;
        tick(3);
    endtask
    task automatic pulse();
        pullReq = 1'b1;
        tick(3);
        pullReq = 1'b0;
        tick(6);
    endtask
    task automatic smp(input int n, input logic rdy);
        repeat (n)
        begin
            filtSmp = {1'b1, rnd()};
            adcSmp = {1'b1, rnd()};
            if (!adcOff)
                mixQ.push_back(adcSmp.data);
            outReady = rdy && rnd() > 16'h7FFF;
            hist.push_back(filtSmp.data);
            if (capt)
                expQ.push_back(filtSmp.data);
            tick(1);
            filtSmp.valid = 1'b0;
            adcSmp.valid = 1'b0;
            tick(1);
        end
    endtask
    task automatic waitSt(input logic [1:0] s);
        for (int i = 0; i < 40 && loopState !== s; i++)
            tick(1);
        check(loopState, s);
    endtask
    always @(posedge clock)
    begin
        rstCnt += dspReset;
        ldCnt += dspLoad;
        mixCnt += mixSmp.valid;
        if (!srst && mixSmp.valid)
        begin
            if (mixQ.size() > 0)
                check(mixSmp.data, mixQ.pop_front());
            else
                extra++;
        end
        if (!srst && outSmp.valid && outReady)
        begin
            if (expQ.size() > 0)
                check(outSmp.data, expQ.pop_front());
            else
                extra++;
        end
    end
    initial
    begin
        #100000;
        num_errors++;
        summarize();
    end
    initial
    begin
        tick(16);
        srst = 1'b0;
        wr(8'h0A, 16'h0000);
        pulse();
        check(rstCnt, 16'h0001);
        check(loopState, 16'h0000);
        wr(8'h0A, 16'h0005);
        check(syncIn, 16'h0000);
        wr(8'h0A, 16'h0001);
        check(syncIn, 16'h0001);
        check(ldCnt, 16'h0001);
        check(rstCnt, 16'h0001);
        wr(8'h0A, 16'h0009);
        smp(3, 1'b0);
        check(mixCnt, 16'h0000);
        wr(8'h0A, 16'h0001);
        smp(3, 1'b0);
        check(mixCnt, 16'h0003);
        $display("idle codes test done");
        wr(8'h0A, 16'h0002);
        pullReq = 1'b1;
        waitSt(mls_pkg::ST_CODE_ARM);
        pullReq = 1'b0;
        tick(2);
        check(syncIn, 16'h0000);
        smp(4, 1'b1);
        waitSt(mls_pkg::ST_CODE_TRIG);
        smp(3, 1'b1);
        for (int i = hist.size() - 4; i < hist.size(); i++)
            expQ.push_back(hist[i]);
        capt = 1'b1;
        pullReq = 1'b1;
        waitSt(mls_pkg::ST_CODE_MEAS);
        pullReq = 1'b0;
        tick(2);
        check(syncIn, 16'h0000);
        smp(4, 1'b1);
        capt = 1'b0;
        smp(2, 1'b1);
        waitSt(mls_pkg::ST_CODE_IDLE);
        smp(2, 1'b1);
        outReady = 1'b1;
        tick(20);
        check(expQ.size(), 16'h0000);
        check(extra, 16'h0000);
        $display("block capture test done");
        pulse();
        waitSt(mls_pkg::ST_CODE_ARM);
        wr(8'h0B, 16'h0003);
        check(loopState, mls_pkg::ST_CODE_ARM);
        wr(8'h0A, 16'h0003);
        waitSt(mls_pkg::ST_CODE_IDLE);
        pulse();
        waitSt(mls_pkg::ST_CODE_ARM);
        $display("force test done");
        blockMode = 1'b0;
        smp(4, 1'b0);
        waitSt(mls_pkg::ST_CODE_TRIG);
        pullReq = 1'b1;
        waitSt(mls_pkg::ST_CODE_MEAS);
        pullReq = 1'b0;
        smp(20, 1'b0);
        check(collecting, 16'h0000);
        waitSt(mls_pkg::ST_CODE_IDLE);
        extra = 0;
        pulse();
        waitSt(mls_pkg::ST_CODE_ARM);
        check(outSmp.valid, 16'h0000);
        wr(8'h0A, 16'h0003);
        outReady = 1'b1;
        tick(10);
        check(extra, 16'h0000);
        $display("overflow test done");
        check(mixQ.size(), 16'h0000);
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        check(syncOe, 16'h0000);
        check(syncOut, 16'h0000);
        check(loopState, 16'h0000);
        summarize();
    end
endmodule
`default_nettype wire

// File: rtl/mls_sequencer.sv
// Notes on behaviour
// - Bits 1-0 of control word select how SYNC edges are used.
// - Code 00 stays idle; SYNC fall resets the DSP section.
// - Code 01 stays idle; SYNC fall triggers DSP register load/readback.
// - Code 10 runs the idle, arm, trigger, measure loop on SYNC.
// - Writing 11 forces idle, then stores 10 for normal looping.
// - Control bit 2 pulls SYNC low; zero releases it.
// - Control bit 3 blocks converter samples from the zoom mixer.
// - All loop changes happen on the sample clock edge.
// - Idle writes nothing into FIFO but keeps draining old data.
// - Any stored code other than 2 holds the loop idle.
// - In normal mode a SYNC fall while idle enters arm.
// - Entering arm flushes old data and starts storing new samples.
// - Arm holds SYNC low until pretrigger met; SYNC high enters trigger.
// - Trigger keeps storing and drops samples beyond the pretrigger span.
// - A SYNC fall during trigger enters measure.
// - Measure keeps collecting and presents FIFO data on output port.
// - Measure holds SYNC low until block done or FIFO overflow.
// - After stopping, SYNC released; SYNC high returns loop to idle.
// - In measure, FIFO writes win over reads.
// - Loop state reported as 0 idle, 1 arm, 2 measure, 3 trigger.
// - Single-block setting one means block mode, zero continuous.
`timescale 1ns/1ps
`default_nettype none

module mls_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic flush,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_ff;
    logic [AW-1:0] rdPtr_ff;
    logic [CW-1:0] cnt_ff;
    logic doWr;
    logic doRd;
    assign inReady = (cnt_ff != CW'(DEPTH));
    assign outValid = (cnt_ff != '0);
    assign outData = mem[rdPtr_ff];
    assign level = cnt_ff;
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction
    always_ff @(posedge clock)
    begin
        if (doWr)
        begin
            mem[wrPtr_ff] <= inData;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst || flush)
        begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (doWr)
            begin
                wrPtr_ff <= bump(wrPtr_ff);
            end
            if (doRd)
            begin
                rdPtr_ff <= bump(rdPtr_ff);
            end
            if (doWr && !doRd)
            begin
                cnt_ff <= cnt_ff + 1'b1;
            end
            else if (doRd && !doWr)
            begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule

module mls_sequencer #(
    parameter int DEPTH = mls_pkg::FIFO_DEPTH,
    parameter int WIDTH = mls_pkg::SMP_W
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic regWrStb,
    input wire logic [7:0] regAddr,
    input wire logic [mls_pkg::CTRL_W-1:0] regWrData,
    input wire logic blockMode,
    input wire logic [$clog2(DEPTH+1)-1:0] preTrigLen,
    input wire logic [$clog2(DEPTH+1)-1:0] blockLen,
    input wire logic syncIn,
    output logic syncOut,
    output logic syncOe,
    input wire mls_pkg::mls_smp_t adcSmp,
    output mls_pkg::mls_smp_t mixSmp,
    input wire mls_pkg::mls_smp_t filtSmp,
    output mls_pkg::mls_smp_t outSmp,
    input wire logic outReady,
    output logic dspReset,
    output logic dspLoad,
    output logic [1:0] loopState,
    output logic collecting
);
    localparam int CW = $clog2(DEPTH+1);
    mls_pkg::mls_ctrl_t ctrl_ff;
    mls_pkg::mls_loop_t state_ff;
    mls_pkg::mls_loop_t nxt_state;
    logic syncS_ff;
    logic syncP_ff;
    logic syncFall;
    logic syncRise;
    logic ctrlWr;
    logic forceIdle;
    logic stopped_ff;
    logic [CW-1:0] postCnt_ff;
    logic fifoFlush;
    logic fifoInValid;
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [WIDTH-1:0] fifoOutData;
    logic [CW-1:0] level;
    logic storing;
    logic drop;
    logic preMet;
    logic blockDone;
    logic overflow;
    logic pullReq;
    logic outLoad;
    function automatic logic [1:0] stateCode(input mls_pkg::mls_loop_t s);
        unique case (s)
            mls_pkg::LOOP_IDLE: stateCode = mls_pkg::ST_CODE_IDLE;
            mls_pkg::LOOP_ARM: stateCode = mls_pkg::ST_CODE_ARM;
            mls_pkg::LOOP_TRIG: stateCode = mls_pkg::ST_CODE_TRIG;
            mls_pkg::LOOP_MEAS: stateCode = mls_pkg::ST_CODE_MEAS;
        endcase
    endfunction

    assign ctrlWr = regWrStb && (regAddr == mls_pkg::MEAS_CTRL_OFS);
    assign forceIdle = ctrlWr
        && (regWrData[mls_pkg::OPC_LSB+:2] == mls_pkg::OPC_FORCE);

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ctrl_ff <= mls_pkg::CTRL_RST[3:0];
        end
        else if (ctrlWr)
        begin
            ctrl_ff.opcode <= forceIdle ? mls_pkg::OPC_NORMAL
                                        : regWrData[mls_pkg::OPC_LSB+:2];
            ctrl_ff.pullSync <= regWrData[mls_pkg::PULL_BIT];
            ctrl_ff.adcOff <= regWrData[mls_pkg::ADCOFF_BIT];
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            syncS_ff <= 1'b1;
            syncP_ff <= 1'b1;
        end
        else
        begin
            syncS_ff <= syncIn;
            syncP_ff <= syncS_ff;
        end
    end

    assign syncFall = syncP_ff && !syncS_ff;
    assign syncRise = !syncP_ff && syncS_ff;

    assign drop = (state_ff == mls_pkg::LOOP_TRIG) && (level != '0)
        && (filtSmp.valid ? (level >= preTrigLen) : (level > preTrigLen));
    assign preMet = level >= preTrigLen;
    assign blockDone = blockMode && (postCnt_ff >= blockLen - preTrigLen);
    assign overflow = !blockMode && filtSmp.valid && !fifoInReady;
    assign storing = (state_ff != mls_pkg::LOOP_IDLE) && !stopped_ff
        && !((state_ff == mls_pkg::LOOP_MEAS) && blockDone);
    assign fifoInValid = storing && filtSmp.valid;

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            mls_pkg::LOOP_IDLE: if (syncFall) nxt_state = mls_pkg::LOOP_ARM;
            mls_pkg::LOOP_ARM: if (syncRise) nxt_state = mls_pkg::LOOP_TRIG;
            mls_pkg::LOOP_TRIG: if (syncFall) nxt_state = mls_pkg::LOOP_MEAS;
            mls_pkg::LOOP_MEAS: if (syncRise) nxt_state = mls_pkg::LOOP_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_ff <= mls_pkg::LOOP_IDLE;
        end
        else if (forceIdle || ctrl_ff.opcode != mls_pkg::OPC_NORMAL)
        begin
            state_ff <= mls_pkg::LOOP_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign fifoFlush = (state_ff == mls_pkg::LOOP_IDLE)
        && (nxt_state == mls_pkg::LOOP_ARM)
        && (ctrl_ff.opcode == mls_pkg::OPC_NORMAL) && !forceIdle;

    always_ff @(posedge clock)
    begin
        if (srst || state_ff != mls_pkg::LOOP_MEAS)
        begin
            stopped_ff <= 1'b0;
            postCnt_ff <= '0;
        end
        else
        begin
            if (overflow || blockDone)
            begin
                stopped_ff <= 1'b1;
            end
            if (fifoInValid && fifoInReady)
            begin
                postCnt_ff <= postCnt_ff + 1'b1;
            end
        end
    end

    assign pullReq = ctrl_ff.pullSync
        || ((state_ff == mls_pkg::LOOP_ARM) && !preMet)
        || ((state_ff == mls_pkg::LOOP_MEAS) && storing && !overflow);

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            syncOe <= 1'b0;
            syncOut <= 1'b0;
        end
        else
        begin
            syncOe <= pullReq;
            syncOut <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            dspReset <= 1'b0;
            dspLoad <= 1'b0;
        end
        else
        begin
            dspReset <= syncFall && ctrl_ff.opcode == mls_pkg::OPC_DSPRST;
            dspLoad <= syncFall && ctrl_ff.opcode == mls_pkg::OPC_DSPLOAD;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            mixSmp <= '0;
        end
        else
        begin
            mixSmp.valid <= adcSmp.valid && !ctrl_ff.adcOff;
            mixSmp.data <= ctrl_ff.adcOff ? '0 : adcSmp.data;
        end
    end

    // present data in idle or measure
    assign outLoad = !outSmp.valid || outReady;
    assign fifoOutReady = drop || (outLoad
        && (state_ff == mls_pkg::LOOP_IDLE
            || (state_ff == mls_pkg::LOOP_MEAS && !fifoInValid)));

    always_ff @(posedge clock)
    begin
        if (srst || fifoFlush)
        begin
            outSmp <= '0;
        end
        else if (outLoad)
        begin
            outSmp.valid <= fifoOutValid && fifoOutReady && !drop;
            outSmp.data <= fifoOutData;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            loopState <= mls_pkg::ST_CODE_IDLE;
            collecting <= 1'b0;
        end
        else
        begin
            loopState <= stateCode(state_ff);
            collecting <= storing;
        end
    end

    mls_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH)
    ) uFifo (
        .clock(clock),
        .srst(srst),
        .flush(fifoFlush),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(filtSmp.data),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData),
        .level(level)
    );
endmodule

`default_nettype wire
